// file: hw/addr_gen_defines.svh
// Constants for the CPU effective-address generation block.
`ifndef ADDR_GEN_DEFINES_SVH
`define ADDR_GEN_DEFINES_SVH
`define PERIPH_PAGE 8'h10
`define RF_SIZE_SMALL 9'h080
`define RF_SIZE_LARGE 9'h100
`define PRIMARY_REG_ADDR 8'h00
`define INDEX_REG_ADDR 8'h01
`define RF_CYCLES_DIRECT 2'h1
`define RF_CYCLES_OTHER 2'h2
`define CODE_BYTES_SHORT_MOVE 2'h1
`define CODE_BYTES_GENERAL_MOVE 2'h3
`endif

// file: hw/addr_gen_pkg.sv
// Types for the CPU effective-address generation block.
package addr_gen_pkg;
    typedef enum logic [4:0] {
        mode_implied = 5'h00,
        mode_register = 5'h01,
        mode_peripheral = 5'h02,
        mode_immediate = 5'h03,
        mode_stack_rel = 5'h04,
        mode_direct = 5'h05,
        mode_indexed = 5'h06,
        mode_indirect = 5'h07,
        mode_offset_indirect = 5'h08,
        mode_pc_relative = 5'h09,
        mode_abs_direct = 5'h0a,
        mode_abs_indexed = 5'h0b,
        mode_abs_indirect = 5'h0c,
        mode_abs_offset_indirect = 5'h0d,
        mode_rel_direct = 5'h0e,
        mode_rel_indexed = 5'h0f,
        mode_rel_indirect = 5'h10,
        mode_rel_offset_indirect = 5'h11
    } addr_mode_t;

    typedef enum logic [2:0] {
        op_other = 3'h0,
        op_copy = 3'h1,
        op_compare = 3'h2,
        op_branch = 3'h3,
        op_call = 3'h4,
        op_jump = 3'h5,
        op_load_sp = 3'h6
    } op_class_t;
endpackage : addr_gen_pkg

// file: hw/ea_adder.sv
// Sixteen-bit wrapping adder of base, constant and signed offset.
module ea_adder (
    input wire logic [15:0] base, // Base address or next-instruction address
    input wire logic [15:0] addend, // Constant, index or pair value
    input wire logic [7:0] offset, // Signed 8-bit offset
    input wire logic use_offset, // Add the sign-extended offset
    output logic [15:0] sum // Sum modulo 65536
);
    logic [15:0] ext;

    always_comb begin
        ext = use_offset ? {{8{offset[7]}}, offset} : 16'h0000;
        sum = base + addend + ext; // RQ23
    end
endmodule : ea_adder

// file: hw/cpu_address_generation.sv
// Effective-address generation for all eighteen operand addressing modes.
//
// Overview of operation
// RQ1: Load-stack instruction copies index register to stack.
// RQ2: Register mode byte selects register-file location.
// RQ3: Register mode takes one cycle, others two.
// RQ4: Locations zero and one are working registers.
// RQ5: Peripheral mode forces upper address byte to 10h.
// RQ6: Immediate mode takes operand from instruction stream.
// RQ7: Stack-relative adds signed byte, truncates, uses primary.
// RQ8: Stack-relative wrap raises no fault.
// RQ9: Stack-relative decoded only for compare and copy.
// RQ10: Long data modes pair with primary, compare/copy only.
// RQ11: Direct mode uses instruction's 16-bit address.
// RQ12: Indexed adds unsigned index to 16-bit constant.
// RQ13: Indirect pair: low from n, high n-1.
// RQ14: Any adjacent register pair may be pointer.
// RQ15: Offset-indirect adds signed byte to pair value.
// RQ16: Short jump loads next address plus offset.
// RQ17: Absolute flow modes load computed 16-bit address.
// RQ18: Relative direct/indexed add constant to next address.
// RQ19: Relative indirect adds pair, plus offset.
// RQ20: Absolute flow modes decoded only for branch/call.
// RQ21: Short jump reaches -128 to +127 bytes.
// RQ22: Relative constant is treated as signed.
// RQ23: Address sums wrap modulo 65536 silently.
module cpu_address_generation
    import addr_gen_pkg::*;
#(
    parameter bit LARGE_RF = 1'b1 // 256-byte register file when set
) (
    input wire logic ref_clk, // 10 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic start, // Decoded operand ready, one-cycle pulse
    input wire addr_mode_t mode, // Addressing mode from decoder
    input wire op_class_t op_class, // Operation class from decoder
    input wire logic [7:0] reg_num, // Register or peripheral number n
    input wire logic [7:0] imm8, // Byte constant or signed offset
    input wire logic [15:0] imm16, // Word constant from instruction
    input wire logic [15:0] next_instr_address, // Next instruction address
    input wire logic [7:0] index_value, // Contents of secondary index reg
    input wire logic [7:0] pair_low, // Contents of register n
    input wire logic [7:0] pair_high, // Contents of register n-1
    input wire logic [7:0] stack_top_pointer, // Current stack pointer
    output logic [7:0] pair_low_addr, // Register-file address of n
    output logic [7:0] pair_high_addr, // Register-file address of n-1
    output logic done, // Result valid, one-cycle pulse
    output logic illegal_mode, // Mode not decoded for this operation
    output logic [15:0] data_addr, // Operand memory address
    output logic data_addr_valid, // Data address is meaningful
    output logic [15:0] other_addr, // Second operand address
    output logic [7:0] imm_operand, // Operand taken from instruction
    output logic imm_valid, // Operand is immediate
    output logic [1:0] rf_cycles, // Memory cycles for the access
    output logic [15:0] pc_load_value, // New program counter
    output logic pc_load, // Program counter is loaded
    output logic [7:0] next_stack, // New stack pointer
    output logic stack_load // Stack pointer is loaded
);

    `include "addr_gen_defines.svh"

    // ************************************************************
    // Registered results
    // ************************************************************
    typedef struct packed {
        logic done;
        logic illegal_mode;
        logic [15:0] data_addr;
        logic data_addr_valid;
        logic [15:0] other_addr;
        logic [7:0] imm_operand;
        logic imm_valid;
        logic [1:0] rf_cycles;
        logic [15:0] pc_load_value;
        logic pc_load;
        logic [7:0] next_stack;
        logic stack_load;
    } state_t;

    state_t cur;
    state_t next_cur;

    // ************************************************************
    // Shared adder
    // ************************************************************
    logic [15:0] pair_value;
    logic [15:0] add_base;
    logic [15:0] add_addend;
    logic add_use_offset;
    logic [15:0] add_sum;
    logic data_class;
    logic flow_class;
    logic rf_wrapped;

    // ************************************************************
    // Pointer pair and operation class
    // ************************************************************
    // Any pair n-1:n works; register 0 pairs with 255 by wrapping.
    assign pair_low_addr = reg_num; // RQ14
    assign pair_high_addr = reg_num - 8'h01; // RQ13
    assign pair_value = {pair_high, pair_low}; // RQ13

    assign data_class = (op_class == op_copy) || (op_class == op_compare);
    assign flow_class = (op_class == op_branch) || (op_class == op_call);

    // On the small register file the upper half is not implemented.
    assign rf_wrapped = LARGE_RF ? 1'b0 : reg_num[7]; // RQ2

    always_comb begin
        add_base = 16'h0000;
        add_addend = 16'h0000;
        add_use_offset = 1'b0;
        case (mode)
            mode_indexed, mode_abs_indexed: begin
                add_base = imm16; // RQ12
                add_addend = {8'h00, index_value}; // RQ12
            end
            mode_offset_indirect, mode_abs_offset_indirect: begin
                add_addend = pair_value; // RQ15
                add_use_offset = 1'b1; // RQ15
            end
            mode_pc_relative: begin
                add_base = next_instr_address; // RQ16
                add_use_offset = 1'b1; // RQ21
            end
            mode_rel_direct: begin
                add_base = next_instr_address; // RQ18
                add_addend = imm16; // RQ22
            end
            mode_rel_indexed: begin
                add_base = next_instr_address + imm16; // RQ18
                add_addend = {8'h00, index_value}; // RQ18
            end
            mode_rel_indirect: begin
                add_base = next_instr_address; // RQ19
                add_addend = pair_value; // RQ19
            end
            mode_rel_offset_indirect: begin
                add_base = next_instr_address; // RQ19
                add_addend = pair_value; // RQ19
                add_use_offset = 1'b1; // RQ19
            end
            default: begin
                add_base = 16'h0000;
            end
        endcase
    end

    ea_adder u_adder (
        .base(add_base),
        .addend(add_addend),
        .offset(imm8),
        .use_offset(add_use_offset),
        .sum(add_sum)
    );

    // ************************************************************
    // Mode classes and refusals
    // ************************************************************
    logic long_data_mode;
    logic abs_flow_mode;
    logic refuse_data;
    logic refuse_flow;
    logic refuse_rf;
    logic [7:0] stack_sum;
    logic [15:0] stack_addr;
    logic [15:0] periph_addr;
    logic [15:0] primary_addr;
    logic [15:0] data_target;
    logic [15:0] flow_target;

    always_comb begin
        long_data_mode = 1'b0;
        abs_flow_mode = 1'b0;
        case (mode)
            mode_stack_rel, mode_direct, mode_indexed, mode_indirect,
            mode_offset_indirect: begin
                long_data_mode = 1'b1; // RQ9 RQ10
            end
            mode_abs_direct, mode_abs_indexed, mode_abs_indirect,
            mode_abs_offset_indirect: begin
                abs_flow_mode = 1'b1; // RQ20
            end
            default: begin
                long_data_mode = 1'b0;
            end
        endcase
    end

    // Refusals are decoded once so that no strobe can disagree with them.
    assign refuse_data = long_data_mode && !data_class; // RQ9 RQ10
    assign refuse_flow = abs_flow_mode && !flow_class; // RQ20
    assign refuse_rf = (mode == mode_register) && rf_wrapped; // RQ2

    // ************************************************************
    // Address candidates
    // ************************************************************
    // The stack sum stays eight bits wide and wraps silently, so keeping
    // it inside the implemented register file is the program's job.
    assign stack_sum = stack_top_pointer + imm8; // RQ7 RQ8
    assign stack_addr = {8'h00, stack_sum}; // RQ7
    assign periph_addr = {`PERIPH_PAGE, reg_num}; // RQ5
    assign primary_addr = {8'h00, `PRIMARY_REG_ADDR}; // RQ7 RQ10

    always_comb begin
        data_target = add_sum;
        case (mode)
            mode_direct: begin
                data_target = imm16; // RQ11
            end
            mode_indirect: begin
                data_target = pair_value; // RQ13
            end
            default: begin
                data_target = add_sum; // RQ12 RQ15
            end
        endcase
    end

    always_comb begin
        flow_target = add_sum;
        case (mode)
            mode_abs_direct: begin
                flow_target = imm16; // RQ17
            end
            mode_abs_indirect: begin
                flow_target = pair_value; // RQ17
            end
            default: begin
                flow_target = add_sum; // RQ16 RQ17 RQ18 RQ19
            end
        endcase
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.done = start;
        next_cur.illegal_mode = 1'b0;
        next_cur.data_addr_valid = 1'b0;
        next_cur.imm_valid = 1'b0;
        next_cur.pc_load = 1'b0;
        next_cur.stack_load = 1'b0;
        if (start) begin
            next_cur.data_addr = 16'h0000;
            next_cur.other_addr = 16'h0000;
            next_cur.imm_operand = 8'h00;
            next_cur.rf_cycles = `RF_CYCLES_OTHER; // RQ3
            next_cur.pc_load_value = 16'h0000;
            case (mode)
                mode_implied: begin
                    if (op_class == op_load_sp) begin
                        next_cur.next_stack = index_value; // RQ1
                        next_cur.stack_load = 1'b1; // RQ1
                    end
                end
                mode_register: begin
                    // Registers 0 and 1 map to the primary and index
                    // registers; the short forms reach the same bytes.
                    next_cur.data_addr = {8'h00, reg_num}; // RQ4
                    next_cur.data_addr_valid = !refuse_rf; // RQ2
                    next_cur.illegal_mode = refuse_rf; // RQ2
                    next_cur.rf_cycles = `RF_CYCLES_DIRECT; // RQ3
                end
                mode_peripheral: begin
                    next_cur.data_addr = periph_addr; // RQ5
                    next_cur.data_addr_valid = 1'b1;
                end
                mode_immediate: begin
                    next_cur.imm_operand = imm8; // RQ6
                    next_cur.imm_valid = 1'b1; // RQ6
                end
                mode_stack_rel: begin
                    if (!refuse_data) begin
                        // Wraps within 8 bits and raises nothing.
                        next_cur.data_addr = stack_addr; // RQ7 RQ8
                        next_cur.other_addr = primary_addr; // RQ7
                        next_cur.data_addr_valid = 1'b1;
                    end else begin
                        next_cur.illegal_mode = 1'b1; // RQ9
                    end
                end
                mode_direct, mode_indexed, mode_indirect,
                mode_offset_indirect: begin
                    if (!refuse_data) begin
                        next_cur.data_addr = data_target; // RQ11 RQ12
                        next_cur.other_addr = primary_addr; // RQ10
                        next_cur.data_addr_valid = 1'b1;
                    end else begin
                        next_cur.illegal_mode = 1'b1; // RQ10
                    end
                end
                mode_pc_relative: begin
                    next_cur.pc_load_value = flow_target; // RQ16
                    next_cur.pc_load = 1'b1; // RQ16
                end
                mode_abs_direct, mode_abs_indexed, mode_abs_indirect,
                mode_abs_offset_indirect: begin
                    if (!refuse_flow) begin
                        next_cur.pc_load_value = flow_target; // RQ17
                        next_cur.pc_load = 1'b1; // RQ17
                    end else begin
                        next_cur.illegal_mode = 1'b1; // RQ20
                    end
                end
                mode_rel_direct, mode_rel_indexed, mode_rel_indirect,
                mode_rel_offset_indirect: begin
                    next_cur.pc_load_value = flow_target; // RQ18 RQ19
                    next_cur.pc_load = 1'b1;
                end
                default: begin
                    next_cur.illegal_mode = 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign done = cur.done;
    assign illegal_mode = cur.illegal_mode;
    assign data_addr = cur.data_addr;
    assign data_addr_valid = cur.data_addr_valid;
    assign other_addr = cur.other_addr;
    assign imm_operand = cur.imm_operand;
    assign imm_valid = cur.imm_valid;
    assign rf_cycles = cur.rf_cycles;
    assign pc_load_value = cur.pc_load_value;
    assign pc_load = cur.pc_load;
    assign next_stack = cur.next_stack;
    assign stack_load = cur.stack_load;

endmodule : cpu_address_generation

// file: sim/rf_model.sv
// Register-file model answering the pair and index reads of the block.
module rf_model (
    input wire logic [7:0] low_addr, // Register n
    input wire logic [7:0] high_addr, // Register n-1
    output logic [7:0] low_data, // Contents of register n
    output logic [7:0] high_data, // Contents of register n-1
    output logic [7:0] index_data // Contents of location one
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i * 37 + 11);
        end
    end
    // Every location answers at once, so a pointer pair may sit anywhere.
    assign low_data = mem[low_addr];
    assign high_data = mem[high_addr];
    assign index_data = mem[8'h01];
endmodule : rf_model

// file: sim/cpu_address_generation_sva.sv
// Assertion checker for the effective-address generation block.
module cpu_address_generation_sva
    import addr_gen_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic start, // Request
    input wire addr_mode_t mode, // Mode
    input wire op_class_t op_class, // Operation
    input wire logic [7:0] reg_num, // Register n
    input wire logic [7:0] imm8, // Byte constant
    input wire logic [15:0] next_instr_address, // Next address
    input wire logic [7:0] index_value, // Index register
    input wire logic [7:0] stack_top_pointer, // Stack pointer
    input wire logic [7:0] pair_low_addr, // Address of n
    input wire logic [7:0] pair_high_addr, // Address of n-1
    input wire logic done, // Answer
    input wire logic illegal_mode, // Refusal
    input wire logic [15:0] data_addr, // Data address
    input wire logic data_addr_valid, // Data strobe
    input wire logic [15:0] other_addr, // Second operand
    input wire logic [1:0] rf_cycles, // Cycle count
    input wire logic [15:0] pc_load_value, // New counter
    input wire logic pc_load, // Counter strobe
    input wire logic [7:0] next_stack, // New stack
    input wire logic stack_load // Stack strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] off16;
    assign off16 = {{8{imm8[7]}}, imm8};
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_long_req;
        start && mode inside {mode_stack_rel, mode_direct, mode_indexed,
            mode_indirect, mode_offset_indirect};
    endsequence
    sequence s_long_ok;
        s_long_req ##0 op_class inside {op_copy, op_compare};
    endsequence
    property p_cycles;
        start |=> done &&
            rf_cycles == (($past(mode) == mode_register) ? 2'h1 : 2'h2);
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle count");
    property p_pair;
        pair_low_addr == reg_num && pair_high_addr == reg_num - 8'h01;
    endproperty
    a_pair: assert property (p_pair) else $error("pair address");
    property p_periph;
        start && mode == mode_peripheral |=>
            data_addr_valid && data_addr == {8'h10, $past(reg_num)};
    endproperty
    a_periph: assert property (p_periph) else $error("periph addr");
    property p_load_sp;
        start && mode == mode_implied && op_class == op_load_sp |=>
            stack_load && next_stack == $past(index_value);
    endproperty
    a_load_sp: assert property (p_load_sp) else $error("stack load");
    property p_long;
        s_long_ok |=> data_addr_valid && !illegal_mode &&
            other_addr == 16'h0000;
    endproperty
    a_long: assert property (p_long) else $error("long data mode");
    property p_stack_rel;
        s_long_ok ##0 mode == mode_stack_rel |=> data_addr ==
            {8'h00, 8'($past(stack_top_pointer) + $past(imm8))};
    endproperty
    a_stack_rel: assert property (p_stack_rel) else $error("stack rel");
    property p_refuse_data;
        s_long_req ##0 !(op_class inside {op_copy, op_compare}) |=>
            illegal_mode && !data_addr_valid;
    endproperty
    a_refuse_data: assert property (p_refuse_data) else $error("data ref");
    property p_refuse_flow;
        start && !(op_class inside {op_branch, op_call}) &&
            mode inside {[mode_abs_direct:mode_abs_offset_indirect]} |=>
            illegal_mode && !pc_load;
    endproperty
    a_refuse_flow: assert property (p_refuse_flow) else $error("flow ref");
    property p_short_jump;
        start && mode == mode_pc_relative |=> pc_load && pc_load_value ==
            16'($past(next_instr_address) + $past(off16));
    endproperty
    a_short_jump: assert property (p_short_jump) else $error("short jump");
endmodule : cpu_address_generation_sva

bind cpu_address_generation cpu_address_generation_sva i_sva (.ref_clk,
    .rst, .start, .mode, .op_class, .reg_num, .imm8, .next_instr_address,
    .index_value, .stack_top_pointer, .pair_low_addr, .pair_high_addr,
    .done, .illegal_mode, .data_addr, .data_addr_valid, .other_addr,
    .rf_cycles, .pc_load_value, .pc_load, .next_stack, .stack_load);

// file: sim/tb_top.sv
// Self-checking testbench sweeping every mode against every operation.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import addr_gen_pkg::*;
    typedef struct packed {
        logic [2:0] sel;
        logic bad;
        logic [1:0] rfc;
        logic [15:0] val;
    } expect_t;
    logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0;
    addr_mode_t mode = mode_implied;
    op_class_t op_class = op_other;
    logic [7:0] reg_num = 8'h00, imm8 = 8'h00, stack_top_pointer = 8'h00;
    logic [15:0] imm16 = 16'h0000, next_instr_address = 16'h0000;
    logic [7:0] index_value, pair_low, pair_high, pair_low_addr;
    logic [7:0] pair_high_addr, imm_operand, next_stack;
    logic [15:0] data_addr, other_addr, pc_load_value;
    logic done, illegal_mode, data_addr_valid, imm_valid, pc_load;
    logic stack_load;
    logic [1:0] rf_cycles;
    int err_total = 0, checked = 0, seed = 32'h669b;
    expect_t q[$];
    expect_t x;
    logic [3:0] strb;
    always #50 ref_clk = ~ref_clk;
    cpu_address_generation i_cpu_address_generation (.ref_clk, .rst,
        .start, .mode, .op_class, .reg_num, .imm8, .imm16,
        .next_instr_address, .index_value, .pair_low, .pair_high,
        .stack_top_pointer, .pair_low_addr, .pair_high_addr, .done,
        .illegal_mode, .data_addr, .data_addr_valid, .other_addr,
        .imm_operand, .imm_valid, .rf_cycles, .pc_load_value, .pc_load,
        .next_stack, .stack_load);
    rf_model i_rf_model (.low_addr(pair_low_addr),
        .high_addr(pair_high_addr), .low_data(pair_low),
        .high_data(pair_high), .index_data(index_value));
    task automatic chk(string what, logic [15:0] e, logic [15:0] s);
        checked++;
        if (e !== s) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    function automatic expect_t expect_of();
        expect_t e;
        logic [15:0] pr, off, idx;
        pr = {i_rf_model.mem[reg_num - 8'h01], i_rf_model.mem[reg_num]};
        off = {{8{imm8[7]}}, imm8};
        idx = {8'h00, i_rf_model.mem[1]};
        e = '{sel: 3'h0, bad: 1'b0, rfc: 2'h2, val: 16'h0000};
        case (mode)
            mode_implied: e.val = idx;
            mode_register: e.val = {8'h00, reg_num};
            mode_peripheral: e.val = {8'h10, reg_num};
            mode_immediate: e.val = {8'h00, imm8};
            mode_stack_rel: e.val = {8'h00, 8'(stack_top_pointer + imm8)};
            mode_direct, mode_abs_direct: e.val = imm16;
            mode_indexed, mode_abs_indexed: e.val = imm16 + idx;
            mode_indirect, mode_abs_indirect: e.val = pr;
            mode_offset_indirect, mode_abs_offset_indirect: e.val = pr + off;
            mode_pc_relative: e.val = next_instr_address + off;
            mode_rel_direct: e.val = next_instr_address + imm16;
            mode_rel_indexed: e.val = next_instr_address + imm16 + idx;
            mode_rel_indirect: e.val = next_instr_address + pr;
            default: e.val = next_instr_address + pr + off;
        endcase
        if (mode == mode_register) e.rfc = 2'h1;
        if (mode == mode_immediate) e.sel = 3'h3;
        if (mode >= mode_pc_relative) e.sel = 3'h1;
        if (mode == mode_implied) e.sel = op_class == op_load_sp ? 3'h2 : 3'h4;
        if ((mode inside {[mode_stack_rel:mode_offset_indirect]} &&
            !(op_class inside {op_copy, op_compare})) ||
            (mode inside {[mode_abs_direct:mode_abs_offset_indirect]} &&
            !(op_class inside {op_branch, op_call}))) begin
            e.bad = 1'b1;
            e.sel = 3'h4;
        end
        return e;
    endfunction : expect_of
    always @(negedge ref_clk) begin
        strb = {data_addr_valid, pc_load, stack_load, imm_valid};
        if (done === 1'b1 && q.size() == 0) begin
            chk("spare done", 16'h0, 16'h1);
        end else if (done === 1'b1) begin
            x = q.pop_front();
            chk("illegal_mode", 16'(x.bad), 16'(illegal_mode));
            chk("rf_cycles", 16'(x.rfc), 16'(rf_cycles));
            case (x.sel)
                3'h0: chk("data_addr", x.val, data_addr);
                3'h1: chk("pc_load_value", x.val, pc_load_value);
                3'h2: chk("next_stack", x.val, 16'(next_stack));
                3'h3: chk("imm_operand", x.val, 16'(imm_operand));
                default: chk("strobes", 16'h0, 16'(strb));
            endcase
            if (x.sel < 3'h4) begin
                chk("strobe", 16'h1, 16'(strb[2'(3 - x.sel)]));
            end
        end
    end
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge ref_clk);
        #5 rst = 1'b0;
        for (int r = 0; r < 4; r++) begin
            for (int m = 0; m < 18; m++) begin
                for (int o = 0; o < 7; o++) begin
                    @(posedge ref_clk);
                    #5 start = 1'b1;
                    mode = addr_mode_t'(m);
                    op_class = op_class_t'(o);
                    reg_num = r == 0 ? 8'h00 : 8'($random(seed));
                    imm8 = r == 0 ? 8'h80 : 8'($random(seed));
                    imm16 = r == 1 ? 16'hffff : 16'($random(seed));
                    next_instr_address = 16'($random(seed));
                    stack_top_pointer = r == 0 ? 8'h01 : 8'($random(seed));
                    q.push_back(expect_of());
                end
            end
        end
        @(posedge ref_clk);
        #5 start = 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("pending", 16'h0, 16'(q.size()));
        summarize();
    end
endmodule : tb_top
